/* File: pkg/adcr_pkg.sv */
// ****************************************************************
// Readout port constants and types
// ****************************************************************
package adcr_pkg;

   // Word layout: result bits on top, two zero pad bits below
   localparam int RES_W   = 14;
   localparam int WORD_W  = 16;
   localparam int NUM_CH  = 8;
   localparam logic [1:0] PAD_BITS = 2'h0;

   // Serial framing: 14 clocks per channel, bit counter ends at 13
   localparam logic [3:0] SER_LAST_BIT = 4'hD;
   localparam logic [3:0] SER_MSB_POS  = 4'hF;

   // Pointer values after reset and at each new conversion
   localparam logic [3:0] READ_IDX_RST = 4'h0;
   localparam logic [2:0] CH_FIRST     = 3'h0;
   localparam logic [2:0] SECOND_SET   = 3'h4;

   // Bus enable patterns and byte-mode upper byte fill
   localparam logic [15:0] OE_WORD = 16'hFFFF;
   localparam logic [15:0] OE_BYTE = 16'h00FF;
   localparam logic [15:0] OE_NONE = 16'h0000;
   localparam logic [7:0]  BYTE_ZERO = 8'h00;

   typedef logic [WORD_W-1:0] adcr_word_t;

   // Results from the converter core, channel 1 at index 0
   typedef struct packed {
      logic [NUM_CH-1:0][RES_W-1:0] code;
   } adcr_results_t;

   // Readout mode, one-hot
   typedef enum logic [2:0] {
      ADCR_PAR  = 3'b001,
      ADCR_BYTE = 3'b010,
      ADCR_SER  = 3'b100
   } adcr_mode_t;

endpackage

/* File: design/adcr_readout.sv */
`timescale 1ns/1ps
// What this block does
// - Busy fall loads 14-bit results plus two zeros
// - Reads after busy fall return new results
// - Reads during busy return previous results
// - Two select pins pick parallel, byte, serial
// - Parallel word bus drives on strobe fall
// - First read gives channel 1, raises marker
// - Chip select enables bus, read advances data
// - Parallel marker drops at second read fall
// - Byte mode: two byte reads per channel
// - Byte-order input picks high or low first
// - Byte marker high for both channel-1 bytes
// - Chip select high: serial outputs released
// - MSB at select fall, shift on rising
// - Fourteen clocks per channel, ascending order
// - Line A channels 1-8, line B 5-8 first
// - Serial marker drops at 14th falling edge
// - Marker also marks channel 5 on line B
module adcr_readout (
   // System side
   input  wire logic                   sys_clk,
   input  wire logic                   srst,
   input  wire logic                   busy,
   input  wire adcr_pkg::adcr_results_t results,
   // Mode pins
   input  wire logic                   iface_select_a,
   input  wire logic                   iface_select_b,
   input  wire logic                   high_byte_first,
   // Host strobes and serial clock
   input  wire logic                   cs_n,
   input  wire logic                   rd_n,
   input  wire logic                   ser_clk,
   // Parallel word and byte bus
   output logic [15:0]                 word_bus,
   output logic [15:0]                 word_bus_oe,
   // Serial lines
   output logic                        serial_out_a,
   output logic                        serial_out_a_oe,
   output logic                        serial_out_b,
   output logic                        serial_out_b_oe,
   // Frame marker
   output logic                        first_channel_marker,
   output logic                        first_channel_marker_oe
);

   // ****************************************************************
   // Functions
   // ****************************************************************

   // Byte of a word, high half when hi is set
   function automatic logic [7:0] byte_pick(input adcr_pkg::adcr_word_t w, input logic hi);
      byte_pick = hi ? w[15:8] : w[7:0];
   endfunction

   // Serial bit of a word for a given bit count since channel start
   function automatic logic ser_bit(input adcr_pkg::adcr_word_t w, input logic [3:0] cnt);
      logic [3:0] pos;
      pos = adcr_pkg::SER_MSB_POS - cnt;
      ser_bit = w[pos];
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************

   localparam int NSYNC = 6;

   logic [NSYNC-1:0]       pin_meta_reg;
   logic [NSYNC-1:0]       pin_sync_reg;
   logic [NSYNC-1:0]       pin_prev_reg;
   logic                   busy_prev_reg;
   adcr_pkg::adcr_word_t   bank_reg [adcr_pkg::NUM_CH];
   adcr_pkg::adcr_word_t   word_out_reg;
   adcr_pkg::adcr_word_t   word_out_next;
   logic [3:0]             read_idx_reg;
   logic                   marker_par_reg;
   logic [2:0]             ser_ch_reg;
   logic [3:0]             ser_cnt_reg;
   logic                   ser_tog_reg;
   logic                   past14_reg;

   wire logic              cs_sync_n;
   wire logic              rd_sync_n;
   wire logic              rd_prev_n;
   wire logic              cs_prev_n;
   wire logic              sel_a_sync;
   wire logic              sel_b_sync;
   wire logic              hbf_sync;
   wire logic              tog_edge;
   wire logic              busy_fall;
   wire logic              cs_active;
   wire logic              cs_rise;
   wire logic              rd_fall;
   wire adcr_pkg::adcr_mode_t mode;
   wire logic [2:0]        par_ch;
   wire logic              byte_hi;
   wire logic              is_first;
   wire logic              ser_marker;
   wire logic [2:0]        ser_ch_b;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************

   // Two stages per pin, third stage only for edge detection
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_meta_reg <= {2'b11, 4'h0};
         pin_sync_reg <= {2'b11, 4'h0};
         pin_prev_reg <= {2'b11, 4'h0};
      end else begin
         pin_meta_reg <= {cs_n, rd_n, iface_select_a, iface_select_b, high_byte_first,
                          ser_tog_reg};
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   assign cs_sync_n  = pin_sync_reg[5];
   assign rd_sync_n  = pin_sync_reg[4];
   assign sel_a_sync = pin_sync_reg[3];
   assign sel_b_sync = pin_sync_reg[2];
   assign hbf_sync   = pin_sync_reg[1];
   assign cs_prev_n  = pin_prev_reg[5];
   assign rd_prev_n  = pin_prev_reg[4];
   assign tog_edge   = pin_sync_reg[0] ^ pin_prev_reg[0];

   // ****************************************************************
   // Mode decode and strobe events
   // ****************************************************************

   // Mode pins are expected static; a change mid-frame is not guarded
   assign mode = !sel_a_sync ? adcr_pkg::ADCR_PAR :
                 (sel_b_sync ? adcr_pkg::ADCR_BYTE : adcr_pkg::ADCR_SER);

   assign busy_fall = busy_prev_reg & ~busy;
   assign cs_active = ~cs_sync_n;
   assign cs_rise   = cs_sync_n & ~cs_prev_n;
   // Tied select and read fall together, so this covers both wirings
   assign rd_fall   = rd_prev_n & ~rd_sync_n & cs_active
                      & (mode != adcr_pkg::ADCR_SER);
   assign par_ch    = (mode == adcr_pkg::ADCR_BYTE) ? read_idx_reg[3:1] : read_idx_reg[2:0];
   assign byte_hi   = hbf_sync ^ read_idx_reg[0];
   assign is_first  = (mode == adcr_pkg::ADCR_BYTE) ? (read_idx_reg[3:1] == 3'h0)
                                                    : (read_idx_reg[2:0] == adcr_pkg::CH_FIRST);

   // Word or byte presented at each read fall
   assign word_out_next = (mode == adcr_pkg::ADCR_BYTE)
                          ? {adcr_pkg::BYTE_ZERO, byte_pick(bank_reg[par_ch], byte_hi)}
                          : bank_reg[par_ch];

   // ****************************************************************
   // Result bank
   // ****************************************************************

   // Loads only at busy fall, so reads during busy see the old sample;
   // the host keeps the port idle around this edge
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         busy_prev_reg <= 1'b0;
      end else begin
         busy_prev_reg <= busy;
      end
   end

   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < adcr_pkg::NUM_CH; i++) begin
         if (srst) begin
            bank_reg[i] <= '0;
         end else if (busy_fall) begin
            bank_reg[i] <= {results.code[i], adcr_pkg::PAD_BITS};
         end
      end
   end

   // ****************************************************************
   // Parallel and byte readout
   // ****************************************************************

   // Read pointer restarts with every new conversion
   always_ff @(posedge sys_clk) begin
      if (srst || busy_fall) begin
         read_idx_reg <= adcr_pkg::READ_IDX_RST;
      end else if (rd_fall) begin
         read_idx_reg <= read_idx_reg + 4'h1;
      end
   end

   // Output word register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         word_out_reg <= '0;
      end else if (rd_fall) begin
         word_out_reg <= word_out_next;
      end else if (cs_rise) begin
         word_out_reg <= '0;                     // No stale upper byte in next frame
      end
   end

   // Marker: channel 1 word, or both channel 1 bytes
   always_ff @(posedge sys_clk) begin
      if (srst || cs_rise) begin
         marker_par_reg <= 1'b0;
      end else if (rd_fall) begin
         marker_par_reg <= is_first;
      end
   end

   // ****************************************************************
   // Serial link domain
   // ****************************************************************

   // Bit count within a channel; cleared while select is high so the
   // serial clock is ignored and the MSB shows at select fall
   always_ff @(posedge ser_clk or posedge cs_n) begin
      if (cs_n) begin
         ser_cnt_reg <= 4'h0;
      end else if (ser_cnt_reg == adcr_pkg::SER_LAST_BIT) begin
         ser_cnt_reg <= 4'h0;
      end else begin
         ser_cnt_reg <= ser_cnt_reg + 4'h1;
      end
   end

   // Channel done toggle; survives select framing so channels chain
   always_ff @(posedge ser_clk or posedge srst) begin
      if (srst) begin
         ser_tog_reg <= 1'b0;
      end else if (!cs_n && ser_cnt_reg == adcr_pkg::SER_LAST_BIT) begin
         ser_tog_reg <= ~ser_tog_reg;
      end
   end

   // Set at the 14th falling serial edge of the first channel
   always_ff @(negedge ser_clk or posedge cs_n) begin
      if (cs_n) begin
         past14_reg <= 1'b0;
      end else if (ser_cnt_reg == adcr_pkg::SER_LAST_BIT) begin
         past14_reg <= 1'b1;
      end
   end

   // Serial channel pointer, advanced by the synced toggle. It settles
   // within three system clocks, well inside half a serial period.
   always_ff @(posedge sys_clk) begin
      if (srst || busy_fall) begin
         ser_ch_reg <= adcr_pkg::CH_FIRST;
      end else if (tog_edge) begin
         ser_ch_reg <= ser_ch_reg + 3'h1;
      end
   end

   // Line B runs four channels ahead of line A
   assign ser_ch_b   = ser_ch_reg ^ adcr_pkg::SECOND_SET;
   // One condition marks channel 1 on A and channel 5 on B together
   assign ser_marker = (ser_ch_reg == adcr_pkg::CH_FIRST) & ~past14_reg;

   // ****************************************************************
   // Pin drive
   // ****************************************************************

   // Enables follow the synced select, a few system clocks late
   assign word_bus     = word_out_reg;
   assign word_bus_oe  = !cs_active ? adcr_pkg::OE_NONE :
                         (mode == adcr_pkg::ADCR_PAR)  ? adcr_pkg::OE_WORD :
                         (mode == adcr_pkg::ADCR_BYTE) ? adcr_pkg::OE_BYTE :
                         adcr_pkg::OE_NONE;
   assign serial_out_a    = ser_bit(bank_reg[ser_ch_reg], ser_cnt_reg);
   assign serial_out_b    = ser_bit(bank_reg[ser_ch_b], ser_cnt_reg);
   assign serial_out_a_oe = cs_active & (mode == adcr_pkg::ADCR_SER);
   assign serial_out_b_oe = cs_active & (mode == adcr_pkg::ADCR_SER);
   assign first_channel_marker    = (mode == adcr_pkg::ADCR_SER) ? ser_marker : marker_par_reg;
   assign first_channel_marker_oe = cs_active;

   // ****************************************************************
   // Assertions
   // ****************************************************************

   default clocking adcr_cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   bank_load_a: assert property (busy_fall |=>
      bank_reg[3] == {$past(results.code[3]), 2'b00})
      else $error("bank not loaded at busy fall");

   old_sample_a: assert property (busy |=> $stable(bank_reg[0]) && $stable(bank_reg[7]))
      else $error("bank changed during busy");

   fresh_frame_a: assert property (busy_fall |=>
      read_idx_reg == 4'h0 && ser_ch_reg == 3'h0)
      else $error("pointers not restarted");

   first_word_a: assert property (rd_fall && mode == adcr_pkg::ADCR_PAR && read_idx_reg == 4'h0
      |=> word_out_reg == bank_reg[0] && marker_par_reg)
      else $error("channel 1 not first");

   par_marker_a: assert property (rd_fall && mode == adcr_pkg::ADCR_PAR && read_idx_reg == 4'h1
      |=> !marker_par_reg ##1 (!marker_par_reg || rd_fall))
      else $error("marker not dropped at second read");

   byte_order_a: assert property (rd_fall && mode == adcr_pkg::ADCR_BYTE && read_idx_reg == 4'h0
      |=> word_out_reg[7:0] == (hbf_sync ? bank_reg[0][15:8] : bank_reg[0][7:0]))
      else $error("wrong first byte");

   byte_marker_a: assert property (rd_fall && mode == adcr_pkg::ADCR_BYTE
      |=> marker_par_reg == ($past(read_idx_reg) < 4'h2))
      else $error("byte marker wrong");

   byte_bus_a: assert property (cs_active && mode == adcr_pkg::ADCR_BYTE
      |-> word_bus_oe == 16'h00FF && word_out_reg[15:8] == 8'h00)
      else $error("byte bus drives upper lines");

   release_a: assert property (cs_sync_n |-> word_bus_oe == 16'h0000
      && !serial_out_a_oe && !serial_out_b_oe && !first_channel_marker_oe)
      else $error("outputs driven with select high");

   ser_step_a: assert property (tog_edge |=> ser_ch_reg == $past(ser_ch_reg) + 3'h1)
      else $error("serial channel not advanced");

   mode_pick_a: assert property (sel_a_sync && !sel_b_sync |-> mode == adcr_pkg::ADCR_SER
      && word_bus_oe == 16'h0000)
      else $error("serial mode drives word bus");

   par_frame_c: cover property (rd_fall && mode == adcr_pkg::ADCR_PAR && read_idx_reg == 4'h7);
   byte_frame_c: cover property (rd_fall && mode == adcr_pkg::ADCR_BYTE && read_idx_reg == 4'hF);
   ser_frame_c: cover property (tog_edge && ser_ch_reg == 3'h3);
   read_busy_c: cover property (busy && rd_fall);

endmodule

/* File: verif/adcr_host.sv */
`timescale 1ns/1ps
// ****************************************************************
// Host controller model
// ****************************************************************
module adcr_host (
   // System clock, used only to pace the strobes
   input  wire logic        sys_clk,
   // Port outputs seen by the host
   input  wire logic [15:0] word_bus,
   input  wire logic [15:0] word_bus_oe,
   input  wire logic        serial_out_a,
   input  wire logic        serial_out_b,
   input  wire logic        first_channel_marker,
   // Strobes made by the host
   output logic             cs_n,
   output logic             rd_n,
   output logic             ser_clk
);
   // Idle levels; serial clock stands high between frames
   initial begin
      cs_n    = 1'b1;
      rd_n    = 1'b1;
      ser_clk = 1'b1;
   end

   // Select change, then time for the synchronisers to settle
   task automatic sel(input logic v);
      @(posedge sys_clk);
      cs_n <= v;
      repeat (4) @(posedge sys_clk);
   endtask

   // One strobe pulse; tied select follows it, only legal for a lone device
   task automatic rd_pulse(input logic tied, output logic [15:0] w, output logic mk,
                           output logic [15:0] oe);
      @(posedge sys_clk);
      rd_n <= 1'b0;
      if (tied) cs_n <= 1'b0;
      repeat (6) @(posedge sys_clk); // Low twice the minimum
      w  = word_bus;
      mk = first_channel_marker;
      oe = word_bus_oe;
      rd_n <= 1'b1;
      if (tied) cs_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask

   // One channel slot: 14 clocks, sampled on falling edges
   task automatic ser_slot(output logic [13:0] a, output logic [13:0] b,
                           output logic [1:0] mk);
      #3.7; // Phase offset keeps the link clock off system edges
      mk[1] = first_channel_marker;
      for (int i = 13; i >= 0; i--) begin
         #80 ser_clk = 1'b0;
         a[i] = serial_out_a;
         b[i] = serial_out_b;
         if (i == 0) #1 mk[0] = first_channel_marker;
         #80 ser_clk = 1'b1;
      end
      repeat (4) @(posedge sys_clk); // Lets the channel pointer cross over
   endtask
endmodule

/* File: verif/adcr_readout_tb.sv */
`timescale 1ns/1ps
// ****************************************************************
// Readout port testbench
// ****************************************************************
module adcr_readout_tb;
   logic                    sys_clk, srst, busy, cs_n, rd_n, ser_clk;
   logic                    iface_select_a, iface_select_b, high_byte_first;
   adcr_pkg::adcr_results_t res, cur;
   logic [15:0]             word_bus, word_bus_oe, w, oe;
   logic                    serial_out_a, serial_out_a_oe, serial_out_b, serial_out_b_oe;
   logic                    first_channel_marker, first_channel_marker_oe, mk;
   logic [13:0]             a, b;
   logic [1:0]              m2;
   int                      n_fail, total_checks, seed;

   adcr_readout i_adcr_readout (.sys_clk, .srst, .busy, .results(res), .iface_select_a,
      .iface_select_b, .high_byte_first, .cs_n, .rd_n, .ser_clk, .word_bus, .word_bus_oe,
      .serial_out_a, .serial_out_a_oe, .serial_out_b, .serial_out_b_oe,
      .first_channel_marker, .first_channel_marker_oe);
   adcr_host i_adcr_host (.sys_clk, .word_bus, .word_bus_oe, .serial_out_a,
      .serial_out_b, .first_channel_marker, .cs_n, .rd_n, .ser_clk);

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Expected word of a channel from the last completed conversion
   function automatic logic [15:0] exp_word(input int ch);
      return {cur.code[ch], 2'h0};
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic set_mode(input logic sa, input logic sb, input logic hb);
      @(posedge sys_clk);
      iface_select_a  <= sa;
      iface_select_b  <= sb;
      high_byte_first <= hb;
      repeat (4) @(posedge sys_clk);
   endtask

   // New random codes go in while busy; full scale on channel 1 when bit 20 of its random draw is set
   task automatic conv_start();
      int r;
      @(posedge sys_clk);
      busy <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         res.code[i] <= (i == 0 && r[20]) ? 14'h3FFF : r[13:0];
      end
      repeat (3) @(posedge sys_clk);
   endtask

   // Busy falls only with select high
   task automatic conv_end();
      @(posedge sys_clk);
      busy <= 1'b0;
      cur = res;
      repeat (3) @(posedge sys_clk);
   endtask

   // Parallel or byte readout; optionally read while busy is still high
   task automatic test_pb(input logic byt, input logic tied, input logic hb,
                          input logic during);
      logic [15:0] e;
      set_mode(byt, byt, hb);
      conv_start();
      if (!during) conv_end();
      if (!tied) i_adcr_host.sel(1'b0);
      if (!tied) chk(word_bus_oe, byt ? 16'h00FF : 16'hFFFF, "enable at select");
      for (int k = 0; k < (byt ? 16 : 8); k++) begin // Sixteen strobes in byte mode
         i_adcr_host.rd_pulse(tied, w, mk, oe);
         e = exp_word(byt ? k / 2 : k);
         if (byt) e = (((k % 2) == 0) == hb) ? {8'h00, e[15:8]} : {8'h00, e[7:0]};
         chk(w, e, "read word");
         chk(oe, byt ? 16'h00FF : 16'hFFFF, "bus enable");
         chk({15'h0, mk}, {15'h0, k < (byt ? 2 : 1)}, "marker");
      end
      if (!tied) i_adcr_host.sel(1'b1);
      chk({word_bus_oe[0], first_channel_marker_oe}, 16'h0, "released");
      if (during) conv_end();
      $display("test done: byte %0d tied %0d order %0d busy %0d", byt, tied, hb, during);
   endtask

   // Serial readout over both lines, one frame or one frame per channel
   task automatic test_ser(input logic framed);
      set_mode(1'b1, 1'b0, 1'b0);
      conv_start();
      conv_end();
      chk({first_channel_marker_oe, serial_out_a_oe, serial_out_b_oe}, 16'h0, "idle");
      i_adcr_host.ser_slot(a, b, m2); // Clocks while deselected must be ignored
      for (int s = 0; s < 8; s++) begin
         if (framed || s == 0) i_adcr_host.sel(1'b0);
         chk({serial_out_a_oe, serial_out_b_oe}, 16'h3, "serial enable");
         chk(word_bus_oe, 16'h0, "word bus in serial");
         i_adcr_host.ser_slot(a, b, m2);
         chk({a, 2'h0}, exp_word(s), "line a");
         chk({b, 2'h0}, exp_word((s + 4) % 8), "line b");
         chk({14'h0, m2}, {14'h0, s == 0, 1'b0}, "serial marker");
         if (framed || s == 7) i_adcr_host.sel(1'b1);
      end
      $display("test done: serial framed %0d", framed);
   endtask

   // Main sequence
   initial begin
      seed = 32'h5f5a;
      n_fail = 0;
      total_checks = 0;
      srst = 1'b1;
      busy = 1'b0;
      iface_select_a = 1'b0;
      iface_select_b = 1'b0;
      high_byte_first = 1'b0;
      res = '0;
      cur = '0;
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      test_pb(1'b0, 1'b1, 1'b0, 1'b0);
      test_pb(1'b0, 1'b0, 1'b0, 1'b0);
      test_pb(1'b0, 1'b0, 1'b0, 1'b1);
      test_pb(1'b1, 1'b0, 1'b1, 1'b0);
      test_pb(1'b1, 1'b0, 1'b0, 1'b1);
      test_ser(1'b0);
      test_ser(1'b1);
      print_verdict();
   end

   // Watchdog, well beyond the roughly 50 us the tests need
   initial begin
      #200000;
      n_fail++;
      print_verdict();
   end
endmodule
